//--- design/iprs_regs.vh
`ifndef IPRS_REGS_VH
`define IPRS_REGS_VH
// register word addresses (one address per register)
`define IPRS_PRIO_ONE_ADDR 4'h0
`define IPRS_PRIO_TWO_ADDR 4'h1
`define IPRS_RCC_ADDR 4'h2
`define IPRS_IRQ_STATUS_ADDR 4'h3
`define IPRS_IRQ_ENABLE_ADDR 4'h4
`define IPRS_IRQ_CLEAR_ADDR 4'h5
`define IPRS_PRIO_HIGH_ADDR 4'h6
// priority one fields
`define IPRS_P1_SLAVE_PORT 7
`define IPRS_P1_CONVERTER 6
`define IPRS_P1_SERIAL_RX 5
`define IPRS_P1_SERIAL_TX 4
`define IPRS_P1_SYNC_SERIAL 3
`define IPRS_P1_CAPCOMP_ONE 2
`define IPRS_P1_TIMER_TWO 1
`define IPRS_P1_TIMER_ONE 0
// priority two fields
`define IPRS_P2_OSC_FAIL 7
`define IPRS_P2_COMPARATOR 6
`define IPRS_P2_UNUSED 5
`define IPRS_P2_NVM_WRITE 4
`define IPRS_P2_BUS_COLL 3
`define IPRS_P2_VOLT_DET 2
`define IPRS_P2_TIMER_THREE 1
`define IPRS_P2_CAPCOMP_TWO 0
// reset cause control fields
`define IPRS_RCC_PRIO_EN 7
`define IPRS_RCC_SBO_EN 6
`define IPRS_RCC_UNUSED 5
`define IPRS_RCC_RESET_INSTR 4
`define IPRS_RCC_WDT_EXPIRY 3
`define IPRS_RCC_POWERDOWN 2
`define IPRS_RCC_POWERON 1
`define IPRS_RCC_BROWNOUT 0
// reset values and masks
`define IPRS_PRIO_ONE_RESET 8'hFF
`define IPRS_PRIO_TWO_RESET 8'hDF
`define IPRS_PRIO_TWO_MASK 8'hDF
`define IPRS_RCC_WR_MASK 8'hD3
// irq status bits
`define IPRS_IRQ_PRIO_CHANGE 0
`define IPRS_IRQ_CAUSE_CHANGE 1
`define IPRS_IRQ_WIDTH 2
`define IPRS_WAIT_CYCLES 2'h1
`endif

//--- design/iprs_word_regs.v
`timescale 1ns/10ps
`default_nettype none
`include "iprs_regs.vh"
// small register store for the two priority words, registered read
module iprs_word_regs
(
	// clock and reset
	input wire ref_clk_i,
	input wire rst_n_i,
	input wire clk_en_i,
	// write side
	input wire wr_en_i,
	input wire wr_sel_i,
	input wire [7:0] wr_data_i,
	// read side
	input wire rd_sel_i,
	output reg [7:0] rd_data_o,
	// both words for the priority logic
	output wire [15:0] words_o
);
	reg [7:0] mem_reg [0:1];
	assign words_o = {mem_reg[1], mem_reg[0]};
	// storage with reset to high priority
	always @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			mem_reg[0] <= `IPRS_PRIO_ONE_RESET;
			mem_reg[1] <= `IPRS_PRIO_TWO_RESET;
			rd_data_o <= 8'h00;
		end
		else if (clk_en_i)
		begin
			if (wr_en_i)
				mem_reg[wr_sel_i] <= wr_data_i;
			rd_data_o <= mem_reg[rd_sel_i];
		end
	end
endmodule
`default_nettype wire

//--- design/iprs_top.v
// How it works
// - there is one priority bit per peripheral source, spread over two priority registers.
// - the priority bits only act while priority levels are enabled, otherwise all are high.
// - priority one holds slave port, converter, rx, tx, sync serial, capcomp one, timers.
// - the sync serial priority sits at bit 3 of priority one.
// - priority two holds osc fail, comparator, zero, nvm, bus coll, volt, timer 3, capcomp 2.
// - the reset cause register keeps flags naming the last reset or wake-up cause.
// - bit 7 of the reset cause register enables priority levels and resets to zero.
// - the soft brown-out enable resets to one when that option is configured, else zero.
// - bits 4 to 0 hold reset, expiry, powerdown, power-on, brown-out flags; bit 5 is zero.
// - the reset values of the cause flags follow configuration and the kind of reset.
`include "iprs_regs.vh"
`timescale 1ns/10ps
`default_nettype none
module iprs_top
#(
	parameter HAS_SLAVE_PORT = 1,
	parameter SOFT_BROWNOUT_OPT = 1
)
(
	// clock, enable, reset
	input wire ref_clk_i,
	input wire clk_en_i,
	input wire reset_n_i,
	// reset cause inputs sampled on reset release
	input wire [4:0] cause_init_i,
	// reset cause events from the core
	input wire reset_instr_evt_i,
	input wire wdt_expiry_evt_i,
	input wire sleep_evt_i,
	input wire clrwdt_evt_i,
	input wire brownout_evt_i,
	// avalon-mm slave
	input wire [3:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	output reg [31:0] avs_readdata_o,
	output reg avs_waitrequest_o,
	// priority outputs
	output reg [15:0] source_high_o,
	output reg priority_levels_enable_o,
	output reg soft_brownout_enable_o,
	output reg irq_o
);
	// reset release
	reg rst_meta_reg;
	reg rst_sync_reg;
	always @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// priority one writable mask
	function [7:0] prio_one_mask;
		input dummy;
		begin
			prio_one_mask = (HAS_SLAVE_PORT != 0) ? 8'hFF : 8'h7F;
		end
	endfunction

	// bus handshake: one wait cycle then answer
	reg busy_reg;
	wire req = (avs_read_i | avs_write_i) & clk_en_i;
	wire take = req & busy_reg;
	wire [7:0] wr_byte = avs_writedata_i[7:0];
	wire wr_prio = take & avs_write_i &
		((avs_address_i == `IPRS_PRIO_ONE_ADDR) | (avs_address_i == `IPRS_PRIO_TWO_ADDR));
	wire [7:0] prio_wr_data = (avs_address_i == `IPRS_PRIO_ONE_ADDR) ?
		(wr_byte & prio_one_mask(1'b0)) : (wr_byte & `IPRS_PRIO_TWO_MASK);
	wire [7:0] prio_rd;
	wire [15:0] prio_words;

	// priority storage, one bit per source over two words
	iprs_word_regs u_words
	(
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_sync_reg),
		.clk_en_i(clk_en_i),
		.wr_en_i(wr_prio),
		.wr_sel_i(avs_address_i[0]),
		.wr_data_i(prio_wr_data),
		.rd_sel_i(avs_address_i[0]),
		.rd_data_o(prio_rd),
		.words_o(prio_words)
	);

	// reset cause control register
	reg [7:0] rcc_reg;
	reg init_done_reg;
	reg [`IPRS_IRQ_WIDTH-1:0] irq_status_reg;
	reg [`IPRS_IRQ_WIDTH-1:0] irq_enable_reg;
	wire wr_rcc = take & avs_write_i & (avs_address_i == `IPRS_RCC_ADDR);
	wire [7:0] rcc_sw = (rcc_reg & ~`IPRS_RCC_WR_MASK) | (wr_byte & `IPRS_RCC_WR_MASK);
	reg [7:0] rcc_next;
	// hardware events override software writes to flags
	always @*
	begin
		rcc_next = wr_rcc ? rcc_sw : rcc_reg;
		if (reset_instr_evt_i)
			rcc_next[`IPRS_RCC_RESET_INSTR] = 1'b0;
		if (wdt_expiry_evt_i)
			rcc_next[`IPRS_RCC_WDT_EXPIRY] = 1'b0;
		if (clrwdt_evt_i)
		begin
			rcc_next[`IPRS_RCC_WDT_EXPIRY] = 1'b1;
			rcc_next[`IPRS_RCC_POWERDOWN] = 1'b1;
		end
		if (sleep_evt_i)
			rcc_next[`IPRS_RCC_POWERDOWN] = 1'b0;
		if (brownout_evt_i)
			rcc_next[`IPRS_RCC_BROWNOUT] = 1'b0;
		rcc_next[`IPRS_RCC_UNUSED] = 1'b0;
	end

	// rcc with config-dependent reset, flags caught after release
	always @(posedge ref_clk_i or negedge rst_sync_reg)
	begin
		if (!rst_sync_reg)
		begin
			rcc_reg <= 8'h00;
			init_done_reg <= 1'b0;
		end
		else if (clk_en_i)
		begin
			if (!init_done_reg)
			begin
				init_done_reg <= 1'b1;
				rcc_reg[`IPRS_RCC_PRIO_EN] <= 1'b0;
				rcc_reg[`IPRS_RCC_SBO_EN] <= (SOFT_BROWNOUT_OPT != 0);
				rcc_reg[`IPRS_RCC_UNUSED] <= 1'b0;
				rcc_reg[4:0] <= cause_init_i;
			end
			else
				rcc_reg <= rcc_next;
		end
	end

	// effective priority per source
	wire [15:0] prio_valid = {`IPRS_PRIO_TWO_MASK, prio_one_mask(1'b0)};
	wire levels_on = rcc_reg[`IPRS_RCC_PRIO_EN];
	wire [15:0] eff_high;
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi = gi + 1)
		begin : g_src
			// high when bit is one, low when zero, all high when levels off
			assign eff_high[gi] = prio_valid[gi] & (~levels_on | prio_words[gi]);
		end
	endgenerate

	// interrupt events, status, enable, clear
	wire prio_event = wr_prio | (wr_rcc & (rcc_sw[`IPRS_RCC_PRIO_EN] != levels_on));
	wire cause_event = init_done_reg & (rcc_next[4:0] != rcc_reg[4:0]) & ~wr_rcc;
	wire wr_irq_en = take & avs_write_i & (avs_address_i == `IPRS_IRQ_ENABLE_ADDR);
	wire wr_irq_clr = take & avs_write_i & (avs_address_i == `IPRS_IRQ_CLEAR_ADDR);
	wire [`IPRS_IRQ_WIDTH-1:0] evt_vec = {cause_event, prio_event};
	wire [`IPRS_IRQ_WIDTH-1:0] clr_vec = wr_irq_clr ? wr_byte[`IPRS_IRQ_WIDTH-1:0] : 2'h0;
	always @(posedge ref_clk_i or negedge rst_sync_reg)
	begin
		if (!rst_sync_reg)
		begin
			irq_status_reg <= 2'h0;
			irq_enable_reg <= 2'h0;
		end
		else if (clk_en_i)
		begin
			// set wins over clear
			irq_status_reg <= (irq_status_reg & ~clr_vec) | evt_vec;
			if (wr_irq_en)
				irq_enable_reg <= wr_byte[`IPRS_IRQ_WIDTH-1:0];
		end
	end

	// read mux
	reg [7:0] rd_mux;
	always @*
	begin
		if (avs_address_i == `IPRS_PRIO_ONE_ADDR)
			rd_mux = prio_words[7:0] & prio_one_mask(1'b0);
		else if (avs_address_i == `IPRS_PRIO_TWO_ADDR)
			rd_mux = prio_words[15:8] & `IPRS_PRIO_TWO_MASK;
		else if (avs_address_i == `IPRS_RCC_ADDR)
			rd_mux = rcc_reg;
		else if (avs_address_i == `IPRS_IRQ_STATUS_ADDR)
			rd_mux = {6'h00, irq_status_reg};
		else if (avs_address_i == `IPRS_IRQ_ENABLE_ADDR)
			rd_mux = {6'h00, irq_enable_reg};
		else if (avs_address_i == `IPRS_PRIO_HIGH_ADDR)
			rd_mux = eff_high[7:0];
		else
			rd_mux = 8'h00;
	end

	// bus answer and registered outputs
	always @(posedge ref_clk_i or negedge rst_sync_reg)
	begin
		if (!rst_sync_reg)
		begin
			busy_reg <= 1'b0;
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h00000000;
			source_high_o <= 16'h0000;
			priority_levels_enable_o <= 1'b0;
			soft_brownout_enable_o <= 1'b0;
			irq_o <= 1'b0;
		end
		else if (clk_en_i)
		begin
			busy_reg <= req & ~busy_reg;
			avs_waitrequest_o <= ~(req & ~busy_reg);
			if (req & ~busy_reg & avs_read_i)
				avs_readdata_o <= {24'h000000, rd_mux};
			source_high_o <= eff_high;
			priority_levels_enable_o <= levels_on;
			soft_brownout_enable_o <= rcc_reg[`IPRS_RCC_SBO_EN];
			irq_o <= |(((irq_status_reg & ~clr_vec) | evt_vec) & irq_enable_reg);
		end
	end
	// prio_rd kept for word store read port, unused by mux
	wire unused_rd = ^prio_rd;
endmodule
`default_nettype wire

//--- verification/iprs_chk.sv
`timescale 1ns/10ps
`default_nettype none
module iprs_chk
#(
	parameter HAS_SLAVE_PORT = 1
)
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	// bus
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	// priority outputs
	input wire logic [15:0] source_high_o,
	input wire logic priority_levels_enable_o,
	input wire logic soft_brownout_enable_o
);
	localparam [7:0] P1_MASK = HAS_SLAVE_PORT ? 8'hFF : 8'h7F;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	// accepted transfers
	wire rd_ack = avs_read_i && !avs_waitrequest_o;
	wire wr_ack = avs_write_i && !avs_waitrequest_o;
	sequence settled; reset_n_i && $past(reset_n_i, 6); endsequence
	sequence req_rise; $rose(avs_read_i || avs_write_i); endsequence
	sequence levels_off; !priority_levels_enable_o ##1 !priority_levels_enable_o; endsequence
	a_wait_answer: assert property (req_rise |-> ##[1:2] !avs_waitrequest_o)
		else $error("request not answered");
	a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low too long");
	a_ack_needs_req: assert property (!avs_waitrequest_o |-> avs_read_i || avs_write_i)
		else $error("answer without request");
	a_off_all_high: assert property (settled ##0 levels_off |-> source_high_o == {8'hDF, P1_MASK})
		else $error("sources not high with levels off");
	a_p2_gap_zero: assert property (rd_ack && avs_address_i == 4'h1 |-> !avs_readdata_o[5])
		else $error("prio two bit 5 not zero");
	a_rcc_gap_zero: assert property (rd_ack && avs_address_i == 4'h2 |-> !avs_readdata_o[5])
		else $error("rcc bit 5 not zero");
	a_unmapped_zero: assert property (rd_ack && avs_address_i > 4'h6 |-> avs_readdata_o == 32'h0)
		else $error("unmapped read not zero");
	a_ple_copy: assert property (wr_ack && avs_address_i == 4'h2 |-> ##2
		priority_levels_enable_o == $past(avs_writedata_i[7], 2)) else $error("level enable wrong");
	a_sbo_copy: assert property (wr_ack && avs_address_i == 4'h2 |-> ##2
		soft_brownout_enable_o == $past(avs_writedata_i[6], 2)) else $error("brownout enable wrong");
	a_p1_level: assert property (wr_ack && avs_address_i == 4'h0 && priority_levels_enable_o
		|-> ##2 !priority_levels_enable_o
		|| source_high_o[7:0] == ($past(avs_writedata_i[7:0], 2) & P1_MASK))
		else $error("prio one level wrong");
endmodule
bind iprs_top iprs_chk #(.HAS_SLAVE_PORT(HAS_SLAVE_PORT)) u_chk (.ref_clk_i(ref_clk_i),
	.reset_n_i(reset_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
	.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
	.source_high_o(source_high_o), .priority_levels_enable_o(priority_levels_enable_o),
	.soft_brownout_enable_o(soft_brownout_enable_o));
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic ref_clk_i, clk_en_i, reset_n_i, avs_read_i, avs_write_i;
	logic reset_instr_evt_i, wdt_expiry_evt_i, sleep_evt_i, clrwdt_evt_i, brownout_evt_i;
	logic [4:0] cause_init_i;
	logic [3:0] avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o;
	logic avs_waitrequest_o, priority_levels_enable_o, soft_brownout_enable_o, irq_o;
	logic [15:0] source_high_o;
	logic [31:0] exp_q[$];
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;
	iprs_top dut (.ref_clk_i(ref_clk_i), .clk_en_i(clk_en_i), .reset_n_i(reset_n_i),
		.cause_init_i(cause_init_i), .reset_instr_evt_i(reset_instr_evt_i),
		.wdt_expiry_evt_i(wdt_expiry_evt_i), .sleep_evt_i(sleep_evt_i),
		.clrwdt_evt_i(clrwdt_evt_i), .brownout_evt_i(brownout_evt_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .source_high_o(source_high_o),
		.priority_levels_enable_o(priority_levels_enable_o),
		.soft_brownout_enable_o(soft_brownout_enable_o), .irq_o(irq_o));
	initial
	begin
		ref_clk_i = 0;
		forever #10 ref_clk_i = ~ref_clk_i;
	end
	task wrap_up;
		$display("mismatches %0d of %0d compares", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one bus transfer, held until waitrequest samples low
	task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		avs_address_i <= a;
		avs_writedata_i <= {24'h0, d};
		avs_read_i <= !w;
		avs_write_i <= w;
		@(posedge ref_clk_i);
		while (avs_waitrequest_o !== 1'b0) @(posedge ref_clk_i);
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge ref_clk_i);
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back({24'h0, e});
		bus(1'b0, a, 8'h0);
	endtask
	// read results checked against the oldest note
	always @(posedge ref_clk_i)
		if (avs_read_i && avs_waitrequest_o === 1'b0)
			chk(avs_readdata_o, exp_q.pop_front());
	// hang guard
	always @(posedge ref_clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			err_total++;
			wrap_up();
		end
	end
	initial
	begin
		logic [7:0] p1, p2, r, rm;
		int s;
		s = $urandom(1214);
		{clk_en_i, reset_n_i, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = 0;
		{reset_instr_evt_i, wdt_expiry_evt_i, sleep_evt_i, clrwdt_evt_i, brownout_evt_i} = 0;
		cause_init_i = 5'($urandom);
		clk_en_i = 1'b1;
		repeat (20) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		repeat (6) @(posedge ref_clk_i);
		rm = {3'b010, cause_init_i};
		rd(4'h0, 8'hFF);
		rd(4'h1, 8'hDF);
		rd(4'h2, rm);
		@(negedge ref_clk_i);
		chk(source_high_o, 16'hDFFF);
		@(posedge ref_clk_i);
		// random priorities under both level settings
		for (int i = 0; i < 6; i++)
		begin
			p1 = 8'($urandom);
			p2 = 8'($urandom);
			r = 8'($urandom) ^ {i[0], 7'h0};
			rm = (r & 8'hD3) | (rm & 8'h0C);
			bus(1'b1, 4'h0, p1);
			bus(1'b1, 4'h1, p2);
			bus(1'b1, 4'h2, r);
			rd(4'h0, p1);
			rd(4'h1, p2 & 8'hDF);
			rd(4'h2, rm);
			rd(4'h6, r[7] ? p1 : 8'hFF);
			@(negedge ref_clk_i);
			chk(priority_levels_enable_o, r[7]);
			chk(soft_brownout_enable_o, r[6]);
			chk(source_high_o, r[7] ? {p2 & 8'hDF, p1} : 16'hDFFF);
			@(posedge ref_clk_i);
		end
		// cause flag events and the interrupt
		bus(1'b1, 4'h4, 8'h02);
		{reset_instr_evt_i, wdt_expiry_evt_i, sleep_evt_i, brownout_evt_i} <= 4'hF;
		@(posedge ref_clk_i);
		{reset_instr_evt_i, wdt_expiry_evt_i, sleep_evt_i, brownout_evt_i} <= 4'h0;
		rm = rm & 8'hE2;
		rd(4'h2, rm);
		bus(1'b1, 4'h5, 8'h03);
		rd(4'h3, 8'h00);
		@(negedge ref_clk_i);
		chk(irq_o, 1'b0);
		@(posedge ref_clk_i);
		clrwdt_evt_i <= 1'b1;
		@(posedge ref_clk_i);
		clrwdt_evt_i <= 1'b0;
		rm = rm | 8'h0C;
		rd(4'h2, rm);
		rd(4'h3, 8'h02);
		@(negedge ref_clk_i);
		chk(irq_o, 1'b1);
		@(posedge ref_clk_i);
		bus(1'b1, 4'h4, 8'h00);
		@(negedge ref_clk_i);
		chk(irq_o, 1'b0);
		@(posedge ref_clk_i);
		bus(1'b1, 4'h4, 8'h01);
		bus(1'b1, 4'h0, 8'h5A);
		rd(4'h3, 8'h03);
		@(negedge ref_clk_i);
		chk(irq_o, 1'b1);
		@(posedge ref_clk_i);
		bus(1'b1, 4'h5, 8'h03);
		bus(1'b1, 4'h3, 8'hFF);
		rd(4'h3, 8'h00);
		@(negedge ref_clk_i);
		chk(irq_o, 1'b0);
		@(posedge ref_clk_i);
		// frozen clock enable keeps flags still
		clk_en_i <= 1'b0;
		sleep_evt_i <= 1'b1;
		@(posedge ref_clk_i);
		sleep_evt_i <= 1'b0;
		clk_en_i <= 1'b1;
		@(posedge ref_clk_i);
		rd(4'h2, rm);
		// clear register and unmapped places read zero
		rd(4'h5, 8'h00);
		for (int a = 7; a < 16; a++)
			rd(4'(a), 8'h00);
		wrap_up();
	end
endmodule
`default_nettype wire
